// File: sac_conversion_control.sv
// Conversion control for a 10-bit successive approximation converter.
`timescale 1ns/1ps
module sac_conversion_control (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire sac_pkg::sac_sfr_req_s sfr_req,
	output logic [7:0]                sfr_rdata,
	input  wire logic                 timer2_overflow,
	input  wire logic                 timer3_overflow,
	input  wire logic                 ext_convert_strobe,
	input  wire logic                 chip_sleep,
	input  wire logic                 conv_irq_enable,
	input  wire logic                 sar_comparator,
	output logic                      conversion_irq,
	output logic                      analog_enable,
	output logic                      track_enable,
	output logic [9:0]                sar_code,
	output logic [3:0]                pair_differential,
	output logic [2:0]                gain_stage_sel
);

	// Converter sequencing states.
	typedef enum logic [1:0] {
		SAC_IDLE,
		SAC_TRACK,
		SAC_CONVERT
	} sac_state_e;

	sac_pkg::sac_control_s control;           // Control register.
	logic [7:0]            converter_config;  // Divider and gain register.
	logic [3:0]            input_pair_config; // Pair configuration bits.
	logic [9:0]            result;            // Last completed result.
	sac_state_e            state;             // Sequencer state.
	logic [4:0]            div_count;         // Conversion clock divider counter.
	logic                  sar_tick;          // One-cycle conversion clock event.
	logic [1:0]            track_count;       // Low-power tracking clocks seen.
	logic [3:0]            bit_index;         // Bit under trial.
	logic                  strobe_prev;       // Strobe sampled one cycle earlier.
	logic                  strobe_rise;       // Strobe rising edge.
	logic                  start_event;       // Selected start of conversion event.
	logic                  finish;            // Last bit decided this cycle.
	logic                  wr_control;        // Write to the control register.

	// Address match for writes, used by several processes.
	function automatic logic is_write(input sac_pkg::sac_sfr_req_s req, input logic [7:0] addr);
		is_write = req.wr && (req.addr == addr);
	endfunction : is_write

	assign wr_control  = is_write(sfr_req, sac_pkg::ADDR_CONTROL);
	assign strobe_rise = ext_convert_strobe && !strobe_prev;

	// Strobe edge history.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			strobe_prev <= 1'b0;
		end else begin
			strobe_prev <= ext_convert_strobe;
		end
	end

	// Start source selection; a start is only taken while enabled and idle.
	always_comb begin
		case (control.start_mode)
			sac_pkg::SAC_START_SOFTWARE: begin
				start_event = wr_control && sfr_req.wdata[sac_pkg::BIT_BUSY];
			end
			sac_pkg::SAC_START_TIMER3: begin
				start_event = timer3_overflow;
			end
			sac_pkg::SAC_START_STROBE: begin
				start_event = strobe_rise;
			end
			sac_pkg::SAC_START_TIMER2: begin
				start_event = timer2_overflow;
			end
			default: begin
				start_event = 1'b0;
			end
		endcase
	end

	// Conversion clock: one tick every divider plus one system clocks.
	always_ff @(posedge clk) begin
		if (sys_rst || state == SAC_IDLE) begin
			div_count <= 5'h00;
			sar_tick  <= 1'b0;
		end else if (div_count >= converter_config[sac_pkg::DIV_MSB:sac_pkg::DIV_LSB]) begin
			div_count <= 5'h00;
			sar_tick  <= 1'b1;
		end else begin
			div_count <= div_count + 5'h01;
			sar_tick  <= 1'b0;
		end
	end

	assign finish = (state == SAC_CONVERT) && sar_tick && (bit_index == 4'h0);

	// Sequencer: idle, optional low-power tracking, bit-by-bit conversion.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state       <= SAC_IDLE;
			track_count <= 2'h0;
			bit_index   <= 4'h0;
			sar_code    <= 10'h000;
		end else if (!control.converter_enable) begin
			state <= SAC_IDLE;
		end else begin
			case (state)
				SAC_IDLE: begin
					// Strobe starts in low-power mode already tracked while low.
					if (start_event && control.lowpower_track_sel &&
					    control.start_mode != sac_pkg::SAC_START_STROBE) begin
						state       <= SAC_TRACK;
						track_count <= 2'h0;
					end else if (start_event) begin
						state     <= SAC_CONVERT;
						bit_index <= sac_pkg::SAR_TOP_BIT;
						sar_code  <= 10'h200;
					end
				end
				SAC_TRACK: begin
					if (sar_tick) begin
						track_count <= track_count + 2'h1;
						if (track_count + 2'h1 == sac_pkg::LP_TRACK_CLOCKS) begin
							state     <= SAC_CONVERT;
							bit_index <= sac_pkg::SAR_TOP_BIT;
							sar_code  <= 10'h200;
						end
					end
				end
				SAC_CONVERT: begin
					if (sar_tick) begin
						// Drop the trial bit when the input is below the trial level.
						if (!sar_comparator) begin
							sar_code[bit_index] <= 1'b0;
						end
						if (bit_index == 4'h0) begin
							state <= SAC_IDLE;
						end else begin
							sar_code[bit_index - 4'h1] <= 1'b1;
							bit_index                  <= bit_index - 4'h1;
						end
					end
				end
				default: begin
					state <= SAC_IDLE;
				end
			endcase
		end
	end

	// Latest result, with the final bit decision folded in.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			result <= 10'h000;
		end else if (finish) begin
			result <= {sar_code[9:1], sar_comparator};
		end
	end

	// Control register; hardware setting of done wins over a software clear.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			control <= sac_pkg::RST_CONTROL;
		end else begin
			if (wr_control) begin
				control.converter_enable   <= sfr_req.wdata[sac_pkg::BIT_ENABLE];
				control.lowpower_track_sel <= sfr_req.wdata[sac_pkg::BIT_LP_TRACK];
				control.start_mode         <= sac_pkg::sac_start_e'(
					sfr_req.wdata[sac_pkg::BIT_MODE_HI:sac_pkg::BIT_MODE_LO]);
				control.left_justify_sel   <= sfr_req.wdata[sac_pkg::BIT_LEFT_JUST];
				control.conversion_done_flag <= sfr_req.wdata[sac_pkg::BIT_DONE];
			end
			control.conversion_active <= (state != SAC_IDLE && !finish) ||
				(state == SAC_IDLE && start_event && control.converter_enable);
			if (finish) begin
				control.conversion_done_flag <= 1'b1;
			end
		end
	end

	// Interrupt request pulse on completion when enabled.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conversion_irq <= 1'b0;
		end else begin
			conversion_irq <= finish && conv_irq_enable;
		end
	end

	// Configuration and pair registers; pairs reset to single-ended.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			converter_config  <= sac_pkg::RST_CONFIG;
			input_pair_config <= sac_pkg::RST_PAIR_CFG[3:0];
		end else begin
			if (is_write(sfr_req, sac_pkg::ADDR_CONFIG)) begin
				converter_config <= sfr_req.wdata;
			end
			if (is_write(sfr_req, sac_pkg::ADDR_PAIR_CFG)) begin
				input_pair_config <= sfr_req.wdata[3:0];
			end
		end
	end

	// Analog controls; tracking stops in sleep, in conversion and when disabled.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			analog_enable     <= 1'b0;
			track_enable      <= 1'b0;
			pair_differential <= 4'h0;
			gain_stage_sel    <= 3'h0;
		end else begin
			analog_enable     <= control.converter_enable;
			pair_differential <= input_pair_config;
			gain_stage_sel    <= converter_config[sac_pkg::GAIN_MSB:sac_pkg::GAIN_LSB];
			if (chip_sleep || !control.converter_enable) begin
				track_enable <= 1'b0;
			end else if (control.lowpower_track_sel) begin
				if (control.start_mode == sac_pkg::SAC_START_STROBE) begin
					track_enable <= (state == SAC_IDLE) && !ext_convert_strobe;
				end else begin
					track_enable <= (state == SAC_TRACK);
				end
			end else begin
				track_enable <= (state == SAC_IDLE);
			end
		end
	end

	// Read data mux, registered; justification chosen at read time.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sfr_rdata <= 8'h00;
		end else begin
			case (sfr_req.addr)
				sac_pkg::ADDR_CONTROL:   sfr_rdata <= control;
				sac_pkg::ADDR_CONFIG:    sfr_rdata <= converter_config;
				sac_pkg::ADDR_PAIR_CFG:  sfr_rdata <= {4'h0, input_pair_config} & sac_pkg::PAIR_CFG_MASK;
				sac_pkg::ADDR_RESULT_HI: begin
					sfr_rdata <= control.left_justify_sel ? result[9:2] : {6'h00, result[9:8]};
				end
				sac_pkg::ADDR_RESULT_LO: begin
					sfr_rdata <= control.left_justify_sel ? {result[1:0], 6'h00} : result[7:0];
				end
				default:                 sfr_rdata <= 8'h00;
			endcase
		end
	end

endmodule : sac_conversion_control

// File: sac_conversion_control_props.sv
// Checker on the conversion control ports.
`timescale 1ns/1ps
module sac_conversion_control_props (
	input wire logic                  clk,
	input wire logic                  sys_rst,
	input wire sac_pkg::sac_sfr_req_s sfr_req,
	input wire logic [7:0]            sfr_rdata,
	input wire logic                  chip_sleep,
	input wire logic                  conv_irq_enable,
	input wire logic                  conversion_irq,
	input wire logic                  analog_enable,
	input wire logic                  track_enable,
	input wire logic [3:0]            pair_differential
);
	// A write that sets the enable bit.
	wire en_req = sfr_req.wr && sfr_req.addr == sac_pkg::ADDR_CONTROL && sfr_req.wdata[sac_pkg::BIT_ENABLE];
	wire rd_req = !sfr_req.wr; // The bus is reading.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// One pair register write followed by an idle cycle.
	sequence pair_wr;
		sfr_req.wr && sfr_req.addr == sac_pkg::ADDR_PAIR_CFG ##1 !sfr_req.wr;
	endsequence
	chk_pair_copy: assert property (pair_wr |=> pair_differential == $past(sfr_req.wdata[3:0], 2))
		else $error("pair outputs differ from written bits");
	chk_pair_upper: assert property (rd_req && sfr_req.addr == sac_pkg::ADDR_PAIR_CFG |=> sfr_rdata[7:4] == 4'h0)
		else $error("pair upper bits read nonzero");
	chk_unmapped_zero: assert property (rd_req && sfr_req.addr == 8'h00 |=> sfr_rdata == 8'h00)
		else $error("unmapped read nonzero");
	chk_reset_single: assert property ($fell(sys_rst) |-> pair_differential == 4'h0 && !analog_enable)
		else $error("not single-ended after reset");
	chk_irq_single: assert property (conversion_irq |=> !conversion_irq)
		else $error("interrupt pulse too long");
	chk_irq_gated: assert property (conversion_irq |-> $past(conv_irq_enable) && $past(analog_enable))
		else $error("interrupt while masked");
	chk_sleep_track: assert property (chip_sleep [*2] |-> !track_enable)
		else $error("tracking during sleep");
	chk_enable_cause: assert property ($rose(analog_enable) |-> $past(en_req) || $past(en_req, 2))
		else $error("enabled without a write");
endmodule : sac_conversion_control_props

// File: sac_far_side.sv
// Model of the analog input seen through the comparator.
`timescale 1ns/1ps
module sac_far_side (
	input wire logic [9:0] level,
	input wire logic [9:0] sar_code,
	output logic           sar_comparator
);
	// The comparator answers at once for the trial code.
	always_comb sar_comparator = (level >= sar_code);
endmodule : sac_far_side

// File: sac_pkg.sv
// Package with register map, field positions and types for the converter control block.
// Notes on behaviour
// - Conversion clock is system clock over divider.
// - Software mode starts on writing one busy.
// - Timer 3 overflow starts conversion in mode.
// - External strobe rising edge starts conversion.
// - Timer 2 overflow starts conversion in mode.
// - Busy is one during conversion, then zero.
// - Busy falling sets done bit five, interrupt.
// - Result in two bytes, justified by select.
// - Default mode tracks whenever no conversion runs.
// - Low-power mode tracks three clocks after start.
// - Low-power strobe mode tracks while strobe low.
// - Tracking may stop during chip sleep.
// - Pair register bits seven to four read zero.
// - Analog parts enabled only by enable bit.
// - After reset all inputs are single-ended.
package sac_pkg;

	// Register addresses on the special function register port.
	localparam logic [7:0] ADDR_CONTROL    = 8'hE8;
	localparam logic [7:0] ADDR_CONFIG     = 8'hBC;
	localparam logic [7:0] ADDR_PAIR_CFG   = 8'hBA;
	localparam logic [7:0] ADDR_RESULT_HI  = 8'hBF;
	localparam logic [7:0] ADDR_RESULT_LO  = 8'hBE;

	// Reset values.
	localparam logic [7:0] RST_CONTROL     = 8'h00;
	localparam logic [7:0] RST_CONFIG      = 8'hF8;
	localparam logic [7:0] RST_PAIR_CFG    = 8'h00;

	// Field positions inside the control register.
	localparam int         BIT_ENABLE      = 7;
	localparam int         BIT_LP_TRACK    = 6;
	localparam int         BIT_DONE        = 5;
	localparam int         BIT_BUSY        = 4;
	localparam int         BIT_MODE_HI     = 3;
	localparam int         BIT_MODE_LO     = 2;
	localparam int         BIT_LEFT_JUST   = 0;

	// Field positions inside the configuration register.
	localparam int         DIV_MSB         = 7;
	localparam int         DIV_LSB         = 3;
	localparam int         GAIN_MSB        = 2;
	localparam int         GAIN_LSB        = 0;

	// Writable bits of the pair configuration register.
	localparam logic [7:0] PAIR_CFG_MASK   = 8'h0F;

	// Conversion geometry and low-power tracking length in conversion clocks.
	localparam int         RESULT_BITS     = 10;
	localparam logic [1:0] LP_TRACK_CLOCKS = 2'h3;
	localparam logic [3:0] SAR_TOP_BIT     = 4'h9;

	// Start of conversion sources.
	typedef enum logic [1:0] {
		SAC_START_SOFTWARE = 2'h0,
		SAC_START_TIMER3   = 2'h1,
		SAC_START_STROBE   = 2'h2,
		SAC_START_TIMER2   = 2'h3
	} sac_start_e;

	// Control register as stored.
	typedef struct packed {
		logic       converter_enable;
		logic       lowpower_track_sel;
		logic       conversion_done_flag;
		logic       conversion_active;
		sac_start_e start_mode;
		logic       spare;
		logic       left_justify_sel;
	} sac_control_s;

	// Register access request from the core.
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} sac_sfr_req_s;

endpackage : sac_pkg

// File: test_sac_conversion_control.sv
// Self-checking testbench for the conversion control block.
`timescale 1ns/1ps
module test_sac_conversion_control;
	localparam logic [7:0] CTL = sac_pkg::ADDR_CONTROL; // Control register.
	localparam logic [7:0] PCF = sac_pkg::ADDR_PAIR_CFG; // Pair register.
	logic                  clk = 1'b0, sys_rst, t2, t3, strb, slp, irq_en, cmp, irq, aen, trk; // Block pins.
	sac_pkg::sac_sfr_req_s req;       // Register request.
	logic [7:0]            rd;        // Read data.
	logic [9:0]            code, lvl; // Trial code and input level.
	logic [3:0]            pd;        // Pair outputs.
	logic [2:0]            gs;        // Gain stage outputs.
	int                    fail_count = 0, checks = 0, cyc = 0, irqs = 0; // Counters.
	sac_conversion_control i_sac_conversion_control (.clk(clk), .sys_rst(sys_rst), .sfr_req(req), .sfr_rdata(rd),
		.timer2_overflow(t2), .timer3_overflow(t3), .ext_convert_strobe(strb), .chip_sleep(slp),
		.conv_irq_enable(irq_en), .sar_comparator(cmp), .conversion_irq(irq), .analog_enable(aen),
		.track_enable(trk), .sar_code(code), .pair_differential(pd), .gain_stage_sel(gs));
	sac_far_side i_sac_far_side (.level(lvl), .sar_code(code), .sar_comparator(cmp));
	// Free running clock.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Counts cycles and interrupt pulses, and cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (irq === 1'b1) irqs++;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// Compares one value and reports a mismatch.
	task automatic check(string name, logic [15:0] exp, logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// One write pulse.
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		req = '{addr: a, wr: 1'b1, wdata: d};
		@(negedge clk);
		req.wr = 1'b0;
	endtask : wr
	// Read data stands one cycle after the address.
	task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		req.addr = a;
		@(negedge clk);
		d = rd;
	endtask : rd_reg
	// Raises the start source of mode m.
	task automatic fire(logic [1:0] m, logic [7:0] c);
		if (m == 2'h0) begin
			wr(CTL, c | 8'h10);
		end else begin
			@(negedge clk);
			t3 = (m == 2'h1);
			t2 = (m == 2'h3);
			strb = (m == 2'h2);
			@(negedge clk);
			{t2, t3, strb} = 3'h0;
		end
	endtask : fire
	// Reset values.
	task automatic t_reset();
		logic [7:0] d;
		rd_reg(PCF, d);
		check("pair reset", 16'h0000, 16'(d));
		rd_reg(sac_pkg::ADDR_CONFIG, d);
		check("config reset", 16'h00F8, 16'(d));
		rd_reg(CTL, d);
		check("control reset", 16'h0000, 16'(d));
		check("pair pins", 16'h0000, 16'(pd));
		$display("t_reset done");
	endtask : t_reset
	// Pair register bits and an unmapped read.
	task automatic t_pair();
		logic [7:0] d;
		wr(PCF, 8'hFF);
		rd_reg(PCF, d);
		check("pair read", 16'h000F, 16'(d));
		check("pair pins", 16'h000F, 16'(pd));
		wr(PCF, 8'hA5);
		rd_reg(PCF, d);
		check("pair part", 16'h0005, 16'(d));
		rd_reg(8'h00, d);
		check("unmapped", 16'h0000, 16'(d));
		$display("t_pair done");
	endtask : t_pair
	// Every start mode, both justifications and tracking modes.
	task automatic t_modes();
		logic [7:0] c, d, hi, lo;
		logic [1:0] m;
		int n, t0, lim;
		for (int k = 0; k < 8; k++) begin
			m = k[1:0];
			lvl = 10'(k * 113 + 243);
			irq_en = k[0];
			c = {1'b1, k[2] ^ k[1], 2'h0, m, 1'b0, k[2]};
			wr(sac_pkg::ADDR_CONFIG, {3'h0, k[1], ~k[1], k[2:0]});
			repeat (190) @(negedge clk);
			check("gain pins", 16'(k[2:0]), 16'(gs));
			wr(CTL, c);
			repeat (2) @(negedge clk);
			check("idle track", 16'(!c[6] || m == 2'h2), 16'(trk));
			check("analog on", 16'h0001, 16'(aen));
			if (m != 2'h3) fire(2'h3, c);
			if (m != 2'h1) fire(2'h1, c);
			if (m != 2'h2) fire(2'h2, c);
			repeat (30) @(negedge clk);
			rd_reg(CTL, d);
			check("wrong source", 16'h0000, 16'(d[5]));
			t0 = cyc;
			fire(m, c);
			rd_reg(CTL, d);
			check("busy", 16'h0001, 16'(d[4]));
			n = 0;
			do begin
				rd_reg(CTL, d);
				n++;
			end while (d[5] !== 1'b1 && n < 200);
			check("done idle", 16'h0002, 16'(d[5:4]));
			lim = ((c[6] && m != 2'h2) ? 13 : 10) * (k[1] + 2);
			check("duration", 16'h0001, 16'(cyc - t0 >= lim && cyc - t0 <= lim + 8));
			rd_reg(sac_pkg::ADDR_RESULT_HI, hi);
			rd_reg(sac_pkg::ADDR_RESULT_LO, lo);
			check("result", k[2] ? {lvl, 6'h00} : {6'h00, lvl}, {hi, lo});
		end
		check("irq count", 16'h0004, 16'(irqs));
		wr(CTL, 8'h00);
		repeat (2) @(negedge clk);
		check("analog off", 16'h0000, 16'(aen));
		$display("t_modes done");
	endtask : t_modes
	// Tracking stops in sleep and resumes after.
	task automatic t_sleep();
		wr(CTL, 8'h80);
		slp = 1'b1;
		repeat (3) @(negedge clk);
		check("sleep track", 16'h0000, 16'(trk));
		slp = 1'b0;
		repeat (3) @(negedge clk);
		check("awake track", 16'h0001, 16'(trk));
		$display("t_sleep done");
	endtask : t_sleep
	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// Main sequence.
	initial begin
		sys_rst = 1'b1;
		req = '0;
		{t2, t3, strb, slp, irq_en} = 5'h00;
		lvl = 10'h000;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_pair();
		t_modes();
		t_sleep();
		tally_and_finish();
	end
endmodule : test_sac_conversion_control
bind sac_conversion_control sac_conversion_control_props i_sac_conversion_control_props (.clk(clk), .sys_rst(sys_rst),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .chip_sleep(chip_sleep), .conv_irq_enable(conv_irq_enable),
	.conversion_irq(conversion_irq), .analog_enable(analog_enable), .track_enable(track_enable),
	.pair_differential(pair_differential));
